// ### rtl/wtp_counter.sv
/*
  Down counter with reload, single-pass or modulo-N operation and an
  output level that toggles at terminal count.
  Assumes start only arrives while stopped and tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module wtp_counter #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic single_pass,
  input wire logic [WIDTH-1:0] reload,
  input wire logic init_level,
  output logic running,
  output logic [WIDTH-1:0] count,
  output logic level,
  output logic tc
);
  logic run_ff;
  logic [WIDTH-1:0] cnt_ff;
  logic lvl_ff;

  initial
  begin
    if (WIDTH < 2)
    begin
      $error("wtp_counter needs WIDTH of at least 2");
    end
  end

  assign running = run_ff;
  assign count = cnt_ff;
  assign level = lvl_ff;
  // Terminal count: a tick seen while the count already sits at zero
  assign tc = run_ff && tick && (cnt_ff == '0);

  // Run state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      run_ff <= 1'b0;
    else if (start)
      run_ff <= 1'b1;
    else if (stop)
      run_ff <= 1'b0;
    // [R07] Single pass stops
    else if (tc && single_pass)
      run_ff <= 1'b0;
  end

  // Count; reload is only sampled here, so bus writes wait for a load
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_ff <= '0;
    // [R03] Load on enable
    // [R13] Restart drops old count
    else if (start)
      cnt_ff <= reload;
    // [R08] Modulo-N reload
    else if (tc && !single_pass)
      cnt_ff <= reload;
    // [R15] Decrement per tick
    else if (run_ff && tick && cnt_ff != '0)
      cnt_ff <= cnt_ff - 1'b1;
  end

  // Output level
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      lvl_ff <= 1'b0;
    else if (start)
      lvl_ff <= init_level;
    // [R04] Toggle at zero
    else if (tc)
      lvl_ff <= ~lvl_ff;
  end
endmodule
`default_nettype wire

// ### rtl/wtp_prescaler.sv
/*
  Clock prescaler: one tick per 1, 2, 4 or 8 reference clocks.
  Assumes sel comes from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wtp_prescaler #(
  parameter int W = wtp_pkg::PRE_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [W-1:0] div_ff;

  initial
  begin
    if (W < 3)
    begin
      $error("wtp_prescaler needs at least 3 bits");
    end
  end

  // Free-running divider; timers start at an arbitrary phase of it
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  // Tick when the selected low bits are all ones
  always_comb
  begin
    unique case (sel)
      2'h0: tick = 1'b1;
      2'h1: tick = div_ff[0];
      2'h2: tick = &div_ff[1:0];
      2'h3: tick = &div_ff[2:0];
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/wtp_timer.sv
/*
  Wide transmit timer with its companion narrow timer, APB register
  file, output pin logic, alternating mode and timeout interrupt.
  Assumes an APB master on ref_clk; the output pin only drives a load.
*/
`timescale 1ns/1ps
`default_nettype none
module wtp_timer #(
  parameter int WIDE_W = 16,
  parameter int NARROW_W = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wide_timer_output,
  output logic narrow_timer_output,
  output logic irq
);
  // Register state
  logic [1:0] mode_ff;
  logic wide_init_ff;
  logic narrow_init_ff;
  logic [7:0] reload_hi_ff;
  logic [7:0] reload_lo_ff;
  logic [7:0] narrow_reload_ff;
  logic wide_single_ff;
  logic narrow_single_ff;
  logic [1:0] wide_pre_ff;
  logic [1:0] narrow_pre_ff;
  logic [1:0] status_ff;
  logic [1:0] int_en_ff;
  logic global_en_ff;
  logic [31:0] prdata_ff;
  logic out_ff;
  // Timer wiring
  logic wide_tick;
  logic narrow_tick;
  logic wide_start;
  logic narrow_start;
  logic wide_stop;
  logic narrow_stop;
  logic wide_run;
  logic narrow_run;
  logic wide_tc;
  logic narrow_tc;
  logic [WIDE_W-1:0] wide_count;
  logic [NARROW_W-1:0] narrow_count;
  logic narrow_level;
  logic [WIDE_W-1:0] wide_reload;
  // Bus decode
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] nxt_prdata;
  logic [1:0] clear_bits;
  logic pingpong;

  initial
  begin
    if (WIDE_W != 16 || NARROW_W != 8)
    begin
      $error("wtp_timer reload layout needs 16 and 8 bit timers");
    end
  end

  // Address decode, shared by write and error paths
  function automatic logic is_mapped(input logic [7:0] a);
    return a == wtp_pkg::NARROW_CTRL_OFS || a == wtp_pkg::SHARED_CTRL_OFS ||
      a == wtp_pkg::WIDE_CTRL_OFS || a == wtp_pkg::RELOAD_HI_OFS ||
      a == wtp_pkg::RELOAD_LO_OFS || a == wtp_pkg::NARROW_RELOAD_OFS ||
      a == wtp_pkg::COUNT_OFS || a == wtp_pkg::INT_STATUS_OFS ||
      a == wtp_pkg::INT_CLEAR_OFS || a == wtp_pkg::INT_ENABLE_OFS ||
      a == wtp_pkg::GLOBAL_EN_OFS;
  endfunction

  // Zero-wait slave; read data is captured in the setup cycle
  assign mapped = is_mapped(paddr);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;
  assign wide_reload = {reload_hi_ff, reload_lo_ff};
  assign pingpong = (mode_ff == wtp_pkg::MODE_PINGPONG);

  // Timer control writes: D7 one starts, D7 zero stops
  // [R11] Either enable starts
  // [R14] Pass end hands over
  assign wide_start = (wr_en && paddr == wtp_pkg::WIDE_CTRL_OFS &&
    pwdata[wtp_pkg::CTRL_EN_BIT] && !wide_run) ||
    (pingpong && narrow_tc && narrow_single_ff && !wide_run);
  assign narrow_start = (wr_en && paddr == wtp_pkg::NARROW_CTRL_OFS &&
    pwdata[wtp_pkg::CTRL_EN_BIT] && !narrow_run) ||
    (pingpong && wide_tc && wide_single_ff && !narrow_run);
  assign wide_stop = wr_en && paddr == wtp_pkg::WIDE_CTRL_OFS &&
    !pwdata[wtp_pkg::CTRL_EN_BIT];
  assign narrow_stop = wr_en && paddr == wtp_pkg::NARROW_CTRL_OFS &&
    !pwdata[wtp_pkg::CTRL_EN_BIT];
  wtp_prescaler u_wide_pre (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sel(wide_pre_ff),
    .tick(wide_tick)
  );
  wtp_prescaler u_narrow_pre (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sel(narrow_pre_ff),
    .tick(narrow_tick)
  );
  // [R09] Reload used at load only
  wtp_counter #(.WIDTH(WIDE_W)) u_wide (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(wide_tick),
    .start(wide_start),
    .stop(wide_stop),
    .single_pass(wide_single_ff),
    .reload(wide_reload),
    .init_level(wide_init_ff),
    .running(wide_run),
    .count(wide_count),
    .level(),
    .tc(wide_tc)
  );
  wtp_counter #(.WIDTH(NARROW_W)) u_narrow (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(narrow_tick),
    .start(narrow_start),
    .stop(narrow_stop),
    .single_pass(narrow_single_ff),
    .reload(narrow_reload_ff),
    .init_level(narrow_init_ff),
    .running(narrow_run),
    .count(narrow_count),
    .level(narrow_level),
    .tc(narrow_tc)
  );
  // Shared control register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_ff <= wtp_pkg::MODE_NORMAL;
      wide_init_ff <= 1'b0;
      narrow_init_ff <= 1'b0;
    end
    else if (wr_en && paddr == wtp_pkg::SHARED_CTRL_OFS)
    begin
      mode_ff <= pwdata[wtp_pkg::SH_MODE_HI:wtp_pkg::SH_MODE_LO];
      wide_init_ff <= pwdata[wtp_pkg::SH_WIDE_INIT_BIT];
      narrow_init_ff <= pwdata[wtp_pkg::SH_NARROW_INIT_BIT];
    end
  end

  // Reload bytes, writable at any time
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reload_hi_ff <= wtp_pkg::RELOAD_RST;
      reload_lo_ff <= wtp_pkg::RELOAD_RST;
      narrow_reload_ff <= wtp_pkg::RELOAD_RST;
    end
    else if (wr_en)
    begin
      if (paddr == wtp_pkg::RELOAD_HI_OFS)
        reload_hi_ff <= pwdata[7:0];
      if (paddr == wtp_pkg::RELOAD_LO_OFS)
        reload_lo_ff <= pwdata[7:0];
      if (paddr == wtp_pkg::NARROW_RELOAD_OFS)
        narrow_reload_ff <= pwdata[7:0];
    end
  end

  // Per-timer control fields
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wide_single_ff <= 1'b0;
      narrow_single_ff <= 1'b0;
      wide_pre_ff <= wtp_pkg::PRE_RST;
      narrow_pre_ff <= wtp_pkg::PRE_RST;
    end
    else if (wr_en && paddr == wtp_pkg::WIDE_CTRL_OFS)
    begin
      wide_single_ff <= pwdata[wtp_pkg::CTRL_SINGLE_BIT];
      wide_pre_ff <= pwdata[wtp_pkg::CTRL_PRE_HI:wtp_pkg::CTRL_PRE_LO];
    end
    else if (wr_en && paddr == wtp_pkg::NARROW_CTRL_OFS)
    begin
      narrow_single_ff <= pwdata[wtp_pkg::CTRL_SINGLE_BIT];
      narrow_pre_ff <= pwdata[wtp_pkg::CTRL_PRE_HI:wtp_pkg::CTRL_PRE_LO];
    end
  end

  // Interrupt enables; control D1 is an alias of the enable register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_en_ff <= 2'h0;
      global_en_ff <= wtp_pkg::GLOBAL_EN_RST;
    end
    else if (wr_en)
    begin
      if (paddr == wtp_pkg::INT_ENABLE_OFS)
        int_en_ff <= pwdata[1:0];
      if (paddr == wtp_pkg::WIDE_CTRL_OFS)
        int_en_ff[wtp_pkg::IRQ_WIDE_BIT] <= pwdata[wtp_pkg::CTRL_IE_BIT];
      if (paddr == wtp_pkg::NARROW_CTRL_OFS)
        int_en_ff[wtp_pkg::IRQ_NARROW_BIT] <= pwdata[wtp_pkg::CTRL_IE_BIT];
      if (paddr == wtp_pkg::GLOBAL_EN_OFS)
        global_en_ff <= pwdata[0];
    end
  end

  // Write-one clears from the clear register or the control flag bits
  always_comb
  begin
    clear_bits = 2'h0;
    if (wr_en && paddr == wtp_pkg::INT_CLEAR_OFS)
      clear_bits = pwdata[1:0];
    if (wr_en && paddr == wtp_pkg::WIDE_CTRL_OFS)
      clear_bits[wtp_pkg::IRQ_WIDE_BIT] = pwdata[wtp_pkg::CTRL_FLAG_BIT];
    if (wr_en && paddr == wtp_pkg::NARROW_CTRL_OFS)
      clear_bits[wtp_pkg::IRQ_NARROW_BIT] = pwdata[wtp_pkg::CTRL_FLAG_BIT];
  end

  // Sticky timeout flags; a set in the clearing cycle wins
  // [R05] Timeout flag set
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      status_ff <= 2'h0;
    else
      status_ff <= (status_ff & ~clear_bits) | {narrow_tc, wide_tc};
  end

  // [R06] Global gate on interrupt
  assign irq = global_en_ff && |(status_ff & int_en_ff);
  // Pin level: force modes first, then initial level on start, then toggle at zero, then idle level
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      out_ff <= 1'b1;
    // [R02] Forced levels
    else if (mode_ff == wtp_pkg::MODE_FORCE0)
      out_ff <= 1'b0;
    else if (mode_ff == wtp_pkg::MODE_FORCE1)
      out_ff <= 1'b1;
    // [R03] Initial level on enable
    else if (wide_start && !(pingpong && narrow_run))
      out_ff <= wide_init_ff;
    // [R04] Toggle at zero
    else if (wide_tc || (pingpong && narrow_tc))
      out_ff <= ~out_ff;
    // [R01] Idle level inverted
    else if (!wide_run && !(pingpong && narrow_run))
      out_ff <= ~wide_init_ff;
  end

  assign wide_timer_output = out_ff;
  assign narrow_timer_output = narrow_level;
  // Read mux
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      wtp_pkg::NARROW_CTRL_OFS:
      begin
        nxt_prdata[wtp_pkg::CTRL_EN_BIT] = narrow_run;
        nxt_prdata[wtp_pkg::CTRL_SINGLE_BIT] = narrow_single_ff;
        nxt_prdata[wtp_pkg::CTRL_FLAG_BIT] =
          status_ff[wtp_pkg::IRQ_NARROW_BIT];
        nxt_prdata[wtp_pkg::CTRL_PRE_HI:wtp_pkg::CTRL_PRE_LO] =
          narrow_pre_ff;
        nxt_prdata[wtp_pkg::CTRL_IE_BIT] = int_en_ff[wtp_pkg::IRQ_NARROW_BIT];
      end
      wtp_pkg::WIDE_CTRL_OFS:
      begin
        nxt_prdata[wtp_pkg::CTRL_EN_BIT] = wide_run;
        nxt_prdata[wtp_pkg::CTRL_SINGLE_BIT] = wide_single_ff;
        nxt_prdata[wtp_pkg::CTRL_FLAG_BIT] = status_ff[wtp_pkg::IRQ_WIDE_BIT];
        nxt_prdata[wtp_pkg::CTRL_PRE_HI:wtp_pkg::CTRL_PRE_LO] = wide_pre_ff;
        nxt_prdata[wtp_pkg::CTRL_IE_BIT] = int_en_ff[wtp_pkg::IRQ_WIDE_BIT];
      end
      wtp_pkg::SHARED_CTRL_OFS:
      begin
        nxt_prdata[wtp_pkg::SH_MODE_HI:wtp_pkg::SH_MODE_LO] = mode_ff;
        nxt_prdata[wtp_pkg::SH_WIDE_INIT_BIT] = wide_init_ff;
        nxt_prdata[wtp_pkg::SH_NARROW_INIT_BIT] = narrow_init_ff;
      end
      wtp_pkg::RELOAD_HI_OFS: nxt_prdata[7:0] = reload_hi_ff;
      wtp_pkg::RELOAD_LO_OFS: nxt_prdata[7:0] = reload_lo_ff;
      wtp_pkg::NARROW_RELOAD_OFS: nxt_prdata[7:0] = narrow_reload_ff;
      wtp_pkg::COUNT_OFS: nxt_prdata = {8'h00, narrow_count, wide_count};
      wtp_pkg::INT_STATUS_OFS: nxt_prdata[1:0] = status_ff;
      wtp_pkg::INT_ENABLE_OFS: nxt_prdata[1:0] = int_en_ff;
      wtp_pkg::GLOBAL_EN_OFS: nxt_prdata[0] = global_en_ff;
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Capture read data in the setup cycle, hold through the access
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      prdata_ff <= 32'h0000_0000;
    else if (rd_setup)
      prdata_ff <= nxt_prdata;
  end

  // Idle level in normal mode tracks the initial-level bit
  a_idle_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode_ff == wtp_pkg::MODE_NORMAL && !wide_run && !wide_start &&
    !wide_tc) ##1 (mode_ff == wtp_pkg::MODE_NORMAL && !wide_run &&
    !wide_start) |=> wide_timer_output == !$past(wide_init_ff)) // [R01]
    else $error("idle output not inverse of initial level");
  a_force_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode_ff == wtp_pkg::MODE_FORCE0 |=> !wide_timer_output) // [R02]
    else $error("forced low not applied");
  a_force_high: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode_ff == wtp_pkg::MODE_FORCE1 |=> wide_timer_output) // [R02]
    else $error("forced high not applied");
  a_start_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    wide_start |=> wide_run && wide_count == $past(wide_reload)) // [R03]
    else $error("enable did not load reload value");
  a_start_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    wide_start && !pingpong && !mode_ff[1]
    |=> wide_timer_output == $past(wide_init_ff)) // [R03]
    else $error("enable did not set initial level");
  a_tc_toggle: assert property (@(posedge ref_clk) disable iff (!resetn)
    wide_tc && mode_ff == wtp_pkg::MODE_NORMAL
    |=> wide_timer_output != $past(wide_timer_output)) // [R04]
    else $error("output not toggled at zero");
  a_tc_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    wide_tc |=> status_ff[wtp_pkg::IRQ_WIDE_BIT] ##0
    (irq || !global_en_ff || !int_en_ff[wtp_pkg::IRQ_WIDE_BIT])) // [R05]
    else $error("timeout flag or interrupt missing");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    !global_en_ff |-> !irq) // [R06]
    else $error("interrupt raised while globally disabled");
  a_single_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
    wide_tc && wide_single_ff |=> !wide_run) // [R07]
    else $error("single pass did not stop");
  a_modulo_reload: assert property (@(posedge ref_clk) disable iff (!resetn)
    wide_tc && !wide_single_ff && !wide_stop
    |=> wide_run && wide_count == $past(wide_reload)) // [R08]
    else $error("modulo-N did not reload");
  a_pp_handoff: assert property (@(posedge ref_clk) disable iff (!resetn)
    pingpong && narrow_tc && narrow_single_ff && !wide_stop
    |=> wide_run) // [R14]
    else $error("alternating handover missed");
  a_count_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !wide_run && !wide_start |=> $stable(wide_count)) // [R15]
    else $error("count moved while stopped");
endmodule
`default_nettype wire

// ### shared/wtp_pkg.sv
/*
  Constants for the wide transmit timer block: register offsets, field
  positions, reset values and output-mode codes.
  Assumes an APB master with 32-bit data and byte addresses on paddr.
*/
// Operation
// [R01] A stopped wide timer in normal or alternating mode drives the inverse of its initial level.
// [R02] Output mode 10 forces the output low and 11 forces it high, enabled or not.
// [R03] Enabling loads high byte times 256 plus low byte and sets the initial output level.
// [R04] Reaching zero in normal or alternating mode toggles the output.
// [R05] Terminal count sets the timeout flag and raises the interrupt when locally enabled.
// [R06] The global interrupt enable gates the timeout interrupt on top of the local enable.
// [R07] Single-pass mode stops the timer at terminal count.
// [R08] Modulo-N mode reloads from the reload bytes at terminal count and keeps counting.
// [R09] Reload bytes may be written any time and only take effect at the next load.
// [R10] Software stops both timers and sets both single-pass and alternating mode first.
// [R11] Alternating mode starts when software enables either timer.
// [R12] Software never programs an initial count of one.
// [R13] Stopping and re-enabling reloads the programmed value, dropping the old count.
// [R14] In alternating mode the end of one timer's pass enables the other timer.
// [R15] The counter decrements once per prescaled tick while enabled and holds otherwise.
package wtp_pkg;
  // Register byte offsets
  localparam logic [7:0] NARROW_CTRL_OFS = 8'h00;
  localparam logic [7:0] SHARED_CTRL_OFS = 8'h04;
  localparam logic [7:0] WIDE_CTRL_OFS = 8'h08;
  localparam logic [7:0] RELOAD_HI_OFS = 8'h0c;
  localparam logic [7:0] RELOAD_LO_OFS = 8'h10;
  localparam logic [7:0] NARROW_RELOAD_OFS = 8'h14;
  localparam logic [7:0] COUNT_OFS = 8'h18;
  localparam logic [7:0] INT_STATUS_OFS = 8'h1c;
  localparam logic [7:0] INT_CLEAR_OFS = 8'h20;
  localparam logic [7:0] INT_ENABLE_OFS = 8'h24;
  localparam logic [7:0] GLOBAL_EN_OFS = 8'h28;
  // Timer control fields (narrow and wide alike)
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_SINGLE_BIT = 6;
  localparam int CTRL_FLAG_BIT = 5;
  localparam int CTRL_PRE_HI = 4;
  localparam int CTRL_PRE_LO = 3;
  localparam int CTRL_IE_BIT = 1;
  // Shared control fields
  localparam int SH_WIDE_INIT_BIT = 0;
  localparam int SH_NARROW_INIT_BIT = 1;
  localparam int SH_MODE_HI = 3;
  localparam int SH_MODE_LO = 2;
  // Interrupt status, clear and enable bit positions
  localparam int IRQ_WIDE_BIT = 0;
  localparam int IRQ_NARROW_BIT = 1;
  // Output modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PINGPONG = 2'h1;
  localparam logic [1:0] MODE_FORCE0 = 2'h2;
  localparam logic [1:0] MODE_FORCE1 = 2'h3;
  // Reset values
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic GLOBAL_EN_RST = 1'b0;
  // Prescaler counter width (divide by up to 8)
  localparam int PRE_W = 3;
endpackage

// ### tb/tb_top.sv
/*
  Self-checking bench for the wide transmit timer: registers, pin
  timing, interrupt and alternating mode.
  Assumes APB without wait states and a load model on the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;}
    wtp_row_t;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wout;
  logic nout;
  logic irq;
  logic [15:0] gap;
  logic [7:0] edges;
  logic [31:0] rd;
  logic [31:0] cnt;
  logic err;
  int n_errors = 0;
  int cmp_count = 0;
  wtp_row_t rows [9];

  wtp_timer u_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wide_timer_output(wout), .narrow_timer_output(nout), .irq(irq));
  wtp_load u_load (.ref_clk(ref_clk), .resetn(resetn), .pin(wout),
    .gap(gap), .edges(edges));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Let register updates reach the pins before sampling
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Bounded wait for the next level change on the pin
  task automatic wait_edge();
    logic [7:0] e0;
    int k;
    e0 = edges;
    k = 0;
    while (edges === e0 && k < 400)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, edges !== e0}, 32'h1);
  endtask

  task automatic end_sim();
    $display("Compares %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: register table first, then hand-written cases
  initial
  begin
    rows = '{'{wtp_pkg::RELOAD_HI_OFS, 32'hab, 32'hab, 1'b0},
      '{wtp_pkg::RELOAD_LO_OFS, 32'h5a, 32'h5a, 1'b0},
      '{wtp_pkg::NARROW_RELOAD_OFS, 32'h33, 32'h33, 1'b0},
      '{wtp_pkg::INT_ENABLE_OFS, 32'h1, 32'h1, 1'b0},
      '{wtp_pkg::GLOBAL_EN_OFS, 32'h1, 32'h1, 1'b0},
      '{wtp_pkg::COUNT_OFS, 32'hffff, 32'h0, 1'b0},
      '{wtp_pkg::INT_STATUS_OFS, 32'h3, 32'h0, 1'b0},
      '{8'h2c, 32'h55, 32'h0, 1'b1},
      '{wtp_pkg::SHARED_CTRL_OFS, 32'hc, 32'hc, 1'b0}};
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk({31'h0, wout}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, nout}, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].q);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    // Every output mode and initial level while stopped
    for (int s = 0; s < 16; s++)
    begin
      apb(1'b1, wtp_pkg::SHARED_CTRL_OFS, 32'(s));
      settle();
      chk({31'h0, wout}, {31'h0, s[3] ? s[2] : ~s[0]});
    end
    apb(1'b1, wtp_pkg::SHARED_CTRL_OFS, 32'h0);
    apb(1'b1, wtp_pkg::RELOAD_HI_OFS, 32'h0);
    apb(1'b1, wtp_pkg::RELOAD_LO_OFS, 32'h3); // never one
    // Period of the toggling pin for each prescale setting
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h02);
      apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h82 | 32'(p << 3));
      settle();
      chk({31'h0, wout}, 32'h0);
      repeat (3) wait_edge();
      chk({16'h0, gap}, 32'(4 << p));
    end
    apb(1'b0, wtp_pkg::INT_STATUS_OFS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b0, wtp_pkg::WIDE_CTRL_OFS, 32'h0);
    chk(rd & 32'ha0, 32'ha0);
    for (int g = 0; g < 4; g++)
    begin
      apb(1'b1, wtp_pkg::GLOBAL_EN_OFS, 32'(g[0]));
      apb(1'b1, wtp_pkg::INT_ENABLE_OFS, 32'(g[1]));
      settle();
      chk({31'h0, irq}, {31'h0, g[0] & g[1]});
    end
    // Reload written mid-period only counts from the next load
    wait_edge();
    apb(1'b1, wtp_pkg::RELOAD_LO_OFS, 32'h5); // never one
    wait_edge();
    chk({16'h0, gap}, 32'd32);
    wait_edge();
    chk({16'h0, gap}, 32'd48);
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h02);
    apb(1'b1, wtp_pkg::INT_CLEAR_OFS, 32'h1);
    apb(1'b0, wtp_pkg::INT_STATUS_OFS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    // Single pass stops after one terminal count
    apb(1'b1, wtp_pkg::RELOAD_LO_OFS, 32'h3);
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'hc2);
    repeat (2) wait_edge();
    cnt = {24'h0, edges};
    repeat (40) @(posedge ref_clk);
    chk({24'h0, edges}, cnt);
    apb(1'b0, wtp_pkg::WIDE_CTRL_OFS, 32'h0);
    chk(rd & 32'h80, 32'h0);
    chk(rd & 32'h20, 32'h20);
    // Flag cleared through the control register's write-one bit
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h20);
    apb(1'b0, wtp_pkg::INT_STATUS_OFS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    // Stopped count holds; restart reloads it
    apb(1'b1, wtp_pkg::RELOAD_HI_OFS, 32'h1);
    apb(1'b1, wtp_pkg::RELOAD_LO_OFS, 32'h0);
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h9a);
    repeat (200) @(posedge ref_clk);
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h1a);
    apb(1'b0, wtp_pkg::COUNT_OFS, 32'h0);
    cnt = rd;
    repeat (30) @(posedge ref_clk);
    apb(1'b0, wtp_pkg::COUNT_OFS, 32'h0);
    chk(rd, cnt);
    chk({31'h0, cnt[15:0] < 16'hf0}, 32'h1);
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h9a);
    apb(1'b0, wtp_pkg::COUNT_OFS, 32'h0);
    chk({31'h0, rd[15:0] > 16'hfd}, 32'h1);
    // Alternating mode set up while both timers are stopped
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'h42);
    apb(1'b1, wtp_pkg::NARROW_CTRL_OFS, 32'h40);
    apb(1'b1, wtp_pkg::SHARED_CTRL_OFS, 32'h4);
    apb(1'b1, wtp_pkg::RELOAD_HI_OFS, 32'h0);
    apb(1'b1, wtp_pkg::RELOAD_LO_OFS, 32'h3); // never one
    apb(1'b1, wtp_pkg::WIDE_CTRL_OFS, 32'hc2);
    repeat (6) wait_edge();
    apb(1'b0, wtp_pkg::INT_STATUS_OFS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, wtp_pkg::SHARED_CTRL_OFS, 32'hc);
    settle();
    chk({31'h0, wout}, 32'h1);
    apb(1'b1, wtp_pkg::SHARED_CTRL_OFS, 32'h8);
    settle();
    chk({31'h0, wout}, 32'h0);
    end_sim();
  end

  // Watchdog: the whole run needs well under this many cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire

// ### tb/wtp_load.sv
/*
  Load on the timer output pin: counts level changes and measures
  the clock cycles between the last two of them.
  Assumes the pin is driven on ref_clk and never floats.
*/
`timescale 1ns/1ps
`default_nettype none
module wtp_load (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pin,
  output logic [15:0] gap,
  output logic [7:0] edges
);
  logic pin_ff;
  logic [15:0] run_ff;

  // Time each level change against the one before; reset level is high
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_ff <= 1'b1;
      run_ff <= 16'h0000;
      gap <= 16'h0000;
      edges <= 8'h00;
    end
    else
    begin
      pin_ff <= pin;
      run_ff <= run_ff + 16'h0001;
      if (pin != pin_ff)
      begin
        gap <= run_ff + 16'h0001;
        run_ff <= 16'h0000;
        edges <= edges + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
